// >>> common/stp_pkg.sv
package stp_pkg;

   // Link timing
   localparam int unsigned STP_SYS_CLK_HZ  = 200_000_000;
   localparam int unsigned STP_LINK_CLK_HZ = 104_000;
   localparam int unsigned STP_SAMPLE_HZ   = 8_000;
   localparam int unsigned STP_TOL_PPM     = 20;

   // Fractional divider: one tick per half period of the link clock
   localparam int          STP_ACC_W    = 28;
   localparam logic [27:0] STP_ACC_MOD  = 28'(STP_SYS_CLK_HZ);
   localparam logic [27:0] STP_ACC_STEP = 28'(2 * STP_LINK_CLK_HZ);

   // Sample word
   localparam int          STP_WORD_BITS = 13;
   localparam logic [3:0]  STP_LAST_BIT  = 4'(STP_WORD_BITS - 1);

   // Receive buffer
   localparam int          STP_FIFO_DEPTH = 4;

   // Mode word is {control 1, control 2}
   typedef enum logic [1:0] {
      STP_MODE_NORMAL   = 2'h0,
      STP_MODE_DOWNLINK = 2'h1,
      STP_MODE_UPLINK   = 2'h2,
      STP_MODE_ACOUSTIC = 2'h3
   } stp_mode_t;

   // Gray along hold -> idle -> low <-> high, low -> idle
   typedef enum logic [1:0] {
      STP_ST_HOLD = 2'h2,
      STP_ST_IDLE = 2'h0,
      STP_ST_LOW  = 2'h1,
      STP_ST_HIGH = 2'h3
   } stp_state_t;

   // Port sends samples to the simulator in these modes
   function automatic logic stp_mode_tx(input stp_mode_t m);
      return (m == STP_MODE_DOWNLINK) || (m == STP_MODE_ACOUSTIC);
   endfunction

   // Port takes samples from the simulator in these modes
   function automatic logic stp_mode_rx(input stp_mode_t m);
      return (m == STP_MODE_UPLINK) || (m == STP_MODE_ACOUSTIC);
   endfunction

endpackage

// >>> sim/stp_sim_model.sv
`timescale 1ns/10ps
`default_nettype none

// Test simulator end of the link, clocked only by the handset's clock
module stp_sim_model (
   input  wire logic        tp_clk,
   input  wire logic        tp_dout,
   input  wire logic [12:0] send_word,
   output var  logic        tp_din,
   output var  logic [12:0] got_word,
   output var  int          got_bits
);
   // One process owns every output, so the data line has one driver
   initial begin
      tp_din   = 1'b0;
      got_word = 13'h0000;
      got_bits = 0;
      // The reset rise of the clock from unknown is not a data edge
      wait (tp_clk === 1'b1);
      forever begin
         @(tp_clk);
         if (tp_clk === 1'b0) begin
            tp_din <= send_word[4'(12 - got_bits % 13)];
         end else begin
            got_word <= {got_word[11:0], tp_dout};
            got_bits <= got_bits + 1;
            // Hold time over after the last bit: line no longer trusted
            if (got_bits % 13 == 12) tp_din <= #1000 ~tp_din;
         end
      end
   end
endmodule

`default_nettype wire

// >>> sim/stp_speech_test_port_bench.sv
`timescale 1ns/10ps
`default_nettype none

module stp_speech_test_port_bench;
   logic        sys_clk;
   logic        rst       = 1'b1;
   logic        rst_n     = 1'b0;
   logic [1:0]  ctl       = 2'h0;
   logic [12:0] tx_sample = 13'h0000;
   logic        tx_valid  = 1'b0;
   logic        rx_ready  = 1'b0;
   logic [12:0] send_word = 13'h0B37;
   logic [12:0] got_word, rx_sample;
   logic        din, tp_clk, tp_dout, tx_ready, rx_valid, trc_rst, cnv_rst;
   logic        active;
   logic [1:0]  mode;
   int          got_bits, n_fall = 0, cyc = 0, n_mismatch = 0, cmp_count = 0;

   stp_speech_test_port #(.FIFO_DEPTH(4)) i_stp_speech_test_port (
      .sys_clk(sys_clk), .rst(rst), .tp_rst_n_pin(rst_n),
      .tp_ctl1_pin(ctl[1]), .tp_ctl2_pin(ctl[0]), .tp_din_pin(din),
      .tp_clk(tp_clk), .tp_dout(tp_dout), .path_tx_sample(tx_sample),
      .path_tx_valid(tx_valid), .path_tx_ready(tx_ready),
      .path_rx_sample(rx_sample), .path_rx_valid(rx_valid),
      .path_rx_ready(rx_ready), .transcoder_rst(trc_rst),
      .converter_rst(cnv_rst), .test_mode(mode), .port_active(active));
   stp_sim_model i_stp_sim_model (.tp_clk(tp_clk), .tp_dout(tp_dout),
      .send_word(send_word), .tp_din(din), .got_word(got_word),
      .got_bits(got_bits));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(negedge tp_clk) n_fall <= n_fall + 1;
   // One word takes about 25000 cycles; three words plus idle gaps
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic check(input logic [12:0] seen, input logic [12:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic sim_reset(input logic [1:0] m);
      ctl   <= m;
      rst_n <= 1'b0;
      repeat (10) @(posedge sys_clk);
      check(mode, m);
      check(trc_rst & cnv_rst, 1'b1);
      rst_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
      check(trc_rst | cnv_rst, 1'b0);
      check(active, m != 2'h0);
   endtask
   task automatic send_tx(input logic [12:0] v);
      tx_sample <= v;
      tx_valid  <= 1'b1;
      do @(posedge sys_clk); while (tx_ready !== 1'b1);
      tx_valid <= 1'b0;
   endtask
   task automatic wait_bits(input int n);
      while (got_bits < n) @(posedge sys_clk);
   endtask
   task automatic t_normal();
      int f;
      check(tp_clk, 1'b1);
      check(tp_dout, 1'b0);
      sim_reset(2'h0);
      f = n_fall;
      repeat (2000) @(posedge sys_clk);
      check(13'(n_fall - f), 13'h0000);
   endtask
   task automatic t_downlink();
      int f;
      sim_reset(2'h1);
      f = n_fall;
      repeat (2000) @(posedge sys_clk);
      check(13'(n_fall - f), 13'h0000);
      send_tx(13'h1A5C);
      wait_bits(13);
      repeat (2000) @(posedge sys_clk);
      check(got_word, 13'h1A5C);
      check(13'(n_fall - f), 13'h000D);
      check(rx_valid, 1'b0);
   endtask
   task automatic t_acoustic();
      sim_reset(2'h3);
      send_tx(13'h1FFE);
      wait_bits(26);
      while (rx_valid !== 1'b1) @(posedge sys_clk);
      check(got_word, 13'h1FFE);
      check(rx_sample, 13'h0B37);
      rx_ready <= 1'b1;
      @(posedge sys_clk);
      rx_ready <= 1'b0;
      @(posedge sys_clk);
      check(rx_valid, 1'b0);
   endtask
   task automatic t_uplink();
      sim_reset(2'h2);
      wait_bits(39);
      check(got_word, 13'h0000);
      while (rx_valid !== 1'b1) @(posedge sys_clk);
      check(rx_sample, 13'h0B37);
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_normal();
      t_downlink();
      t_acoustic();
      t_uplink();
      final_report();
   end
endmodule

`default_nettype wire

// >>> sim/stp_speech_test_port_chk.sv
`timescale 1ns/10ps
`default_nettype none

module stp_chk (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       tp_rst_n_pin,
   input wire logic       tp_clk,
   input wire logic       tp_dout,
   input wire logic       path_tx_ready,
   input wire logic       path_rx_valid,
   input wire logic       transcoder_rst,
   input wire logic [1:0] test_mode,
   input wire logic       port_active
);
   logic        last_r;
   logic [10:0] cnt_r;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Run length of the present link clock level; wraps in long idles
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         last_r <= 1'b1;
         cnt_r  <= 11'h000;
      end else begin
         last_r <= tp_clk;
         cnt_r  <= (tp_clk != last_r) ? 11'h001 : cnt_r + 11'h001;
      end
   end
   property p_ni; (test_mode == 2'h0)[*3] |-> tp_clk; endproperty
   a_ni: assert property (p_ni)
      else $error("link clock runs in normal mode");
   property p_ron; (!tp_rst_n_pin)[*6] |-> transcoder_rst; endproperty
   a_ron: assert property (p_ron)
      else $error("transcoder not held in reset");
   property p_rof; tp_rst_n_pin[*6] |-> !transcoder_rst; endproperty
   a_rof: assert property (p_rof)
      else $error("transcoder reset after release");
   property p_df; $changed(tp_dout) && !tp_clk |-> $fell(tp_clk); endproperty
   a_df: assert property (p_df)
      else $error("data out moved while clock low");
   property p_lo;
      $rose(tp_clk) |-> cnt_r inside {[11'h3C1:11'h3C2]};
   endproperty
   a_lo: assert property (p_lo)
      else $error("link clock low phase wrong length");
   property p_tx;
      path_tx_ready |-> test_mode[0] && $past(test_mode[0]);
   endproperty
   a_tx: assert property (p_tx)
      else $error("send path ready in a mode without output");
   property p_ri; $rose(path_rx_valid) |-> test_mode[1]; endproperty
   a_ri: assert property (p_ri)
      else $error("sample received in a mode without input");
   property p_fa; $fell(tp_clk) |-> port_active && !transcoder_rst; endproperty
   a_fa: assert property (p_fa)
      else $error("clock pulse outside an active test");
endmodule

bind stp_speech_test_port stp_chk i_stp_chk (.sys_clk, .rst, .tp_rst_n_pin,
   .tp_clk, .tp_dout, .path_tx_ready, .path_rx_valid, .transcoder_rst,
   .test_mode, .port_active);

`default_nettype wire

// >>> src/stp_fifo.sv
`timescale 1ns/10ps
`default_nettype none

// Shift-style FIFO: the head word always sits in slot 0, so the read
// side sees flip-flops directly and no read multiplexer.
module stp_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 4
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);

   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [CW-1:0]               count;
      logic                        in_rdy;
      logic                        out_vld;
   } stp_fifo_t;

   stp_fifo_t r_r;
   stp_fifo_t r_nxt;

   always_comb begin
      logic          pop;
      logic          push;
      logic [CW-1:0] wr_idx;
      r_nxt  = r_r;
      pop    = r_r.out_vld && out_ready;
      push   = in_valid && r_r.in_rdy;
      wr_idx = r_r.count - CW'(pop);
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            r_nxt.mem[i] = r_r.mem[i + 1];
         end
      end
      if (push) begin
         for (int i = 0; i < DEPTH; i++) begin
            if (CW'(i) == wr_idx) begin
               r_nxt.mem[i] = in_data;
            end
         end
      end
      r_nxt.count = r_r.count - CW'(pop) + CW'(push);
      if (flush) begin
         r_nxt.count = '0;
      end
      r_nxt.out_vld = (r_nxt.count != '0);
      r_nxt.in_rdy  = (r_nxt.count != CW'(DEPTH));
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign in_ready  = r_r.in_rdy;
   assign out_valid = r_r.out_vld;
   assign out_data  = r_r.mem[0];

endmodule

`default_nettype wire

// >>> src/stp_speech_test_port.sv
`timescale 1ns/10ps
`default_nettype none

module stp_speech_test_port
   import stp_pkg::*;
#(
   parameter int FIFO_DEPTH = STP_FIFO_DEPTH
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        tp_rst_n_pin,
   input  wire logic        tp_ctl1_pin,
   input  wire logic        tp_ctl2_pin,
   input  wire logic        tp_din_pin,
   output logic             tp_clk,
   output logic             tp_dout,
   input  wire logic [12:0] path_tx_sample,
   input  wire logic        path_tx_valid,
   output logic             path_tx_ready,
   output logic [12:0]      path_rx_sample,
   output logic             path_rx_valid,
   input  wire logic        path_rx_ready,
   output logic             transcoder_rst,
   output logic             converter_rst,
   output logic [1:0]       test_mode,
   output logic             port_active
);

   typedef struct packed {
      logic [3:0]           meta;
      logic [3:0]           sync;
      logic [STP_ACC_W-1:0] acc;
      logic                 tick;
      stp_state_t           st;
      stp_mode_t            mode;
      logic [3:0]           bit_cnt;
      logic [12:0]          tx_hold;
      logic                 tx_full;
      logic                 tx_rdy;
      logic [12:0]          tx_sh;
      logic [12:0]          rx_sh;
      logic                 push;
      logic                 clk_o;
      logic                 dout;
      logic                 trc_rst;
      logic                 conv_rst;
      logic                 active;
   } stp_top_t;

   // Transcoder held in reset and the clock parked high until the
   // simulator's own reset line has been seen released
   localparam stp_top_t TOP_RST = '{
      st:       STP_ST_HOLD,
      mode:     STP_MODE_NORMAL,
      clk_o:    1'b1,
      trc_rst:  1'b1,
      conv_rst: 1'b1,
      default:  '0
   };

   stp_top_t r_r;
   stp_top_t r_nxt;

   logic fifo_in_ready;

   always_comb begin
      logic                 rst_n_s;
      logic                 din_s;
      stp_mode_t            mode_in;
      logic [STP_ACC_W:0]   acc_sum;
      logic                 start_ok;

      r_nxt = r_r;

      // Two flops on every pin from the simulator
      r_nxt.meta = {tp_din_pin, tp_ctl2_pin, tp_ctl1_pin, tp_rst_n_pin};
      r_nxt.sync = r_r.meta;
      rst_n_s    = r_r.sync[0];
      din_s      = r_r.sync[3];
      mode_in    = stp_mode_t'({r_r.sync[1], r_r.sync[2]});

      // Phase accumulator keeps the mean rate exact; jitter is one
      // system cycle, far below the bit time
      acc_sum = {1'b0, r_r.acc} + {1'b0, STP_ACC_STEP};
      if (acc_sum >= {1'b0, STP_ACC_MOD}) begin
         r_nxt.acc  = STP_ACC_W'(acc_sum - {1'b0, STP_ACC_MOD});
         r_nxt.tick = 1'b1;
      end else begin
         r_nxt.acc  = STP_ACC_W'(acc_sum);
         r_nxt.tick = 1'b0;
      end

      r_nxt.push     = 1'b0;
      r_nxt.trc_rst  = !rst_n_s;
      r_nxt.conv_rst = !rst_n_s;

      // Take one sample from the speech path into the holding word
      if (path_tx_valid && r_r.tx_rdy) begin
         r_nxt.tx_hold = path_tx_sample;
         r_nxt.tx_full = 1'b1;
      end

      // A word starts only when every direction in use is ready
      start_ok = (r_r.mode != STP_MODE_NORMAL)
               && (!stp_mode_tx(r_r.mode) || r_r.tx_full)
               && (!stp_mode_rx(r_r.mode) || fifo_in_ready);

      case (r_r.st)
         STP_ST_HOLD: begin
            r_nxt.clk_o   = 1'b1;
            r_nxt.dout    = 1'b0;
            r_nxt.bit_cnt = '0;
            r_nxt.tx_full = 1'b0;
            r_nxt.mode    = mode_in;
            if (rst_n_s) begin
               r_nxt.st = STP_ST_IDLE;
            end
         end
         STP_ST_IDLE: begin
            if (r_r.tick && start_ok) begin
               // Falling edge puts out the first (sign) bit
               r_nxt.clk_o   = 1'b0;
               r_nxt.bit_cnt = '0;
               if (stp_mode_tx(r_r.mode)) begin
                  r_nxt.tx_sh   = r_r.tx_hold;
                  r_nxt.tx_full = 1'b0;
                  r_nxt.dout    = r_r.tx_hold[12];
               end else begin
                  r_nxt.tx_sh = '0;
                  r_nxt.dout  = 1'b0;
               end
               r_nxt.st = STP_ST_LOW;
            end
         end
         STP_ST_LOW: begin
            if (r_r.tick) begin
               // Rising edge: simulator data has been stable for
               // half a bit, the sync delay is negligible against it
               r_nxt.clk_o = 1'b1;
               r_nxt.rx_sh = {r_r.rx_sh[11:0], din_s};
               if (r_r.bit_cnt == STP_LAST_BIT) begin
                  r_nxt.push = stp_mode_rx(r_r.mode);
                  r_nxt.st   = STP_ST_IDLE;
               end else begin
                  r_nxt.st = STP_ST_HIGH;
               end
            end
         end
         STP_ST_HIGH: begin
            if (r_r.tick) begin
               r_nxt.clk_o   = 1'b0;
               r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
               r_nxt.tx_sh   = {r_r.tx_sh[11:0], 1'b0};
               r_nxt.dout    = r_r.tx_sh[11];
               r_nxt.st      = STP_ST_LOW;
            end
         end
         default: begin
            r_nxt.st = STP_ST_HOLD;
         end
      endcase

      // Return to normal aborts the test at once; any other change
      // of mode waits for the next reset pulse
      if (r_r.st != STP_ST_HOLD && r_r.mode != STP_MODE_NORMAL
          && mode_in == STP_MODE_NORMAL) begin
         r_nxt.st    = STP_ST_HOLD;
         r_nxt.clk_o = 1'b1;
         r_nxt.dout  = 1'b0;
         r_nxt.push  = 1'b0;
      end

      // Simulator reset restarts the whole port, mid-word included
      if (!rst_n_s) begin
         r_nxt.st      = STP_ST_HOLD;
         r_nxt.clk_o   = 1'b1;
         r_nxt.dout    = 1'b0;
         r_nxt.push    = 1'b0;
         r_nxt.tx_full = 1'b0;
      end

      r_nxt.tx_rdy = !r_nxt.tx_full && stp_mode_tx(r_nxt.mode)
                   && (r_nxt.st != STP_ST_HOLD);
      r_nxt.active = (r_nxt.mode != STP_MODE_NORMAL)
                   && (r_nxt.st != STP_ST_HOLD);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r_r <= TOP_RST;
      end else begin
         r_r <= r_nxt;
      end
   end

   // Received words wait here for the encoder or converter; when it
   // stalls the buffer fills and the link clock stops
   stp_fifo #(
      .WIDTH (STP_WORD_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .flush     (r_r.trc_rst),
      .in_data   (r_r.rx_sh),
      .in_valid  (r_r.push),
      .in_ready  (fifo_in_ready),
      .out_data  (path_rx_sample),
      .out_valid (path_rx_valid),
      .out_ready (path_rx_ready)
   );

   assign tp_clk         = r_r.clk_o;
   assign tp_dout        = r_r.dout;
   assign path_tx_ready  = r_r.tx_rdy;
   assign transcoder_rst = r_r.trc_rst;
   assign converter_rst  = r_r.conv_rst;
   assign test_mode      = r_r.mode;
   assign port_active    = r_r.active;

endmodule

`default_nettype wire
